//--- rtl/clk_switch_pkg.sv
// Purpose: Shared constants and types for the system clock switch.
// Assumes: 125 MHz sampling clock; oscillator levels arrive as pins.
// Notes:   Register offsets and mode codes are local to this block.
package clk_switch_pkg;

  // Register map
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;

  // Control register fields
  localparam int ALT_BIT    = 0;
  localparam int PLL_SW_BIT = 1;
  localparam int PLL_EN_BIT = 2;
  localparam int STABLE_BIT = 3;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Status register fields
  localparam int STAT_SRC_LSB  = 0;
  localparam int STAT_FREEZE   = 2;
  localparam int STAT_MODE_LSB = 4;

  // Transition counts, in rising edges of the counted oscillator
  localparam logic [10:0] XTAL_START_EDGES = 11'h400;
  localparam logic [10:0] SYNC_EDGES       = 11'h008;

  // Lock wait, in microseconds, and its count of system cycles
  localparam int CLK_FREQ_MHZ     = 125;
  localparam int PLL_LOCK_TIME_US = 2000;
  localparam int PLL_LOCK_CYCLES  = PLL_LOCK_TIME_US * CLK_FREQ_MHZ;
  localparam int LOCK_CNT_W       = 18;

  typedef enum logic [3:0] {
    LOW_POWER_CRYSTAL   = 4'h0,
    MID_CRYSTAL         = 4'h1,
    HIGH_SPEED_CRYSTAL  = 4'h2,
    RESISTOR_CAP_OSC    = 4'h3,
    EXT_CLOCK           = 4'h4,
    EXT_CLOCK_GPIO      = 4'h5,
    CRYSTAL_PLL_FIXED   = 4'h6,
    RESISTOR_CAP_GPIO   = 4'h7,
    EXT_CLOCK_PLL_SOFT  = 4'h8,
    EXT_CLOCK_PLL_FIXED = 4'h9,
    CRYSTAL_PLL_SOFT    = 4'ha,
    RESISTOR_CAP_GPIO_B = 4'hb
  } osc_mode_t;

  typedef enum logic [1:0] {
    SRC_PRIMARY = 2'b00,
    SRC_PLL     = 2'b01,
    SRC_TIMER1  = 2'b10
  } src_t;

  typedef enum logic [2:0] {
    ST_WAKE  = 3'b000,
    ST_RUN   = 3'b001,
    ST_PARK  = 3'b010,
    ST_START = 3'b011,
    ST_LOCK  = 3'b100,
    ST_SYNC  = 3'b101,
    ST_SLEEP = 3'b110
  } sw_state_t;

endpackage

//--- rtl/system_clock_switch.sv
// Purpose: System clock source selection with glitch-free switching.
// Assumes: Oscillator inputs are sampled levels; config is stable from reset.
// Notes:   Generated clock is a sampled image of the chosen source.
// Behaviour
// RL1: Resistor-capacitor mode drives oscillator/4 on output pin
// RL2: Resistor-capacitor I/O mode hands pin to port bit
// RL3: Switching allowed only when enable_n programmed low
// RL4: Alt switch zero primary, one Timer1 oscillator
// RL5: Alt switch cleared on every reset
// RL6: Alt switch forced zero unless enabled and Timer1
// RL7: PLL switch selects PLL; forced zero unless locked
// RL8: Fixed PLL modes hold PLL switch zero
// RL9: PLL enable fixed one, soft writable, else zero
// RL10: Stable flag reads one only when PLL usable
// RL11: Alt switch wins over PLL switch
// RL12: Upper four control bits read zero
// RL13: Wait eight incoming edges before using source
// RL14: Freeze at next first quarter, resume after eight
// RL15: Crystal switch-back waits 1024 oscillator periods
// RL16: Crystal with PLL adds lock delay after start-up
// RL17: External clock with PLL waits lock delay only
// RL18: Resistor-capacitor or external clock resumes after eight edges
// RL19: Outside party may drive clock into input pin
// RL20: Start-up delay only crystal modes, reset or wake
// RL21: Stable flag set after lock, cleared on disable
// RL22: Mux changes only with both clocks low; code switches active on a target rising edge, generated clock held low
`timescale 1ns/10ps
`default_nettype none

module system_clock_switch #(
  parameter int LOCK_CYCLES = clk_switch_pkg::PLL_LOCK_CYCLES
) (
  input  wire logic       sys_clk_in,
  input  wire logic       nrst_in,
  // Register port
  input  wire logic [3:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  // Configuration word and neighbouring control
  input  wire logic [3:0] main_osc_config_in,
  input  wire logic       clock_switch_enable_n_in,
  input  wire logic       timer1_osc_enable_in,
  input  wire logic       first_quarter_phase_in,
  input  wire logic       sleep_in,
  // Oscillator sources
  input  wire logic       osc_in_pin_in,
  input  wire logic       timer1_osc_in,
  input  wire logic       pll_clk_in,
  // Output pin and its port bit
  input  wire logic       osc_out_pin_in,
  output logic            osc_out_pin_out,
  output logic            osc_out_pin_oe_n_out,
  input  wire logic       gpio_a_bit6_val_in,
  input  wire logic       gpio_a_bit6_oe_n_in,
  output logic            gpio_a_bit6_pin_out,
  // Generated clock and processor freeze
  output logic            sys_clk_gen_out,
  output logic            cpu_freeze_out
);

  // Synchronisers: prim, timer1, pll, out pin
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  logic [3:0] sync_c;
  logic [3:0] rise;

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sync_a <= 4'h0;
      sync_b <= 4'h0;
      sync_c <= 4'h0;
    end else begin
      sync_a <= {osc_out_pin_in, pll_clk_in, timer1_osc_in, osc_in_pin_in};
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  assign rise = sync_b & ~sync_c;

  // Configuration capture after reset release
  clk_switch_pkg::osc_mode_t mode;
  logic                      cfg_sw_en_n;
  logic                      cfg_done;

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mode        <= clk_switch_pkg::RESISTOR_CAP_OSC;
      cfg_sw_en_n <= 1'b1;
      cfg_done    <= 1'b0;
    end else if (!cfg_done) begin
      mode        <= clk_switch_pkg::osc_mode_t'(main_osc_config_in);
      cfg_sw_en_n <= clock_switch_enable_n_in;
      cfg_done    <= 1'b1;
    end
  end

  // Mode classes
  logic is_xtal;
  logic fixed_pll;
  logic soft_pll;
  logic rc_div_mode;
  logic gpio_mode;

  always_comb begin
    is_xtal     = 1'b0;
    fixed_pll   = 1'b0;
    soft_pll    = 1'b0;
    rc_div_mode = 1'b0;
    gpio_mode   = 1'b0;
    unique case (mode)
      clk_switch_pkg::LOW_POWER_CRYSTAL,
      clk_switch_pkg::MID_CRYSTAL,
      clk_switch_pkg::HIGH_SPEED_CRYSTAL: is_xtal = 1'b1;
      clk_switch_pkg::RESISTOR_CAP_OSC,
      clk_switch_pkg::EXT_CLOCK: rc_div_mode = 1'b1;
      clk_switch_pkg::EXT_CLOCK_GPIO,
      clk_switch_pkg::RESISTOR_CAP_GPIO,
      clk_switch_pkg::RESISTOR_CAP_GPIO_B: gpio_mode = 1'b1;
      clk_switch_pkg::CRYSTAL_PLL_FIXED: begin
        is_xtal   = 1'b1;
        fixed_pll = 1'b1;
      end
      clk_switch_pkg::EXT_CLOCK_PLL_FIXED: begin
        fixed_pll = 1'b1;
        gpio_mode = 1'b1;
      end
      clk_switch_pkg::CRYSTAL_PLL_SOFT: begin
        is_xtal  = 1'b1;
        soft_pll = 1'b1;
      end
      clk_switch_pkg::EXT_CLOCK_PLL_SOFT: begin
        soft_pll  = 1'b1;
        gpio_mode = 1'b1;
      end
      default: rc_div_mode = 1'b1;
    endcase
  end

  // Control register bits and PLL lock timing
  logic                                    alt_sw;
  logic                                    pll_sw;
  logic                                    pll_en;
  logic                                    pll_en_eff;
  logic                                    pll_stable;
  logic                                    switch_allowed;
  logic                                    wr_ctrl;
  logic                                    osc_halted;
  logic [clk_switch_pkg::LOCK_CNT_W-1:0]   lock_cnt;
  localparam logic [clk_switch_pkg::LOCK_CNT_W-1:0] LOCK_LAST =
    clk_switch_pkg::LOCK_CNT_W'(LOCK_CYCLES - 1);

  assign wr_ctrl        = wr_in && (addr_in == clk_switch_pkg::ADDR_CTRL);
  assign switch_allowed = !cfg_sw_en_n && timer1_osc_enable_in; // RL3 RL6
  assign pll_en_eff     = fixed_pll || (soft_pll && pll_en); // RL9

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      alt_sw <= clk_switch_pkg::CTRL_RESET[clk_switch_pkg::ALT_BIT]; // RL5
    end else if (!switch_allowed) begin
      alt_sw <= 1'b0; // RL6
    end else if (wr_ctrl) begin
      alt_sw <= wdata_in[clk_switch_pkg::ALT_BIT]; // RL4
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pll_en <= clk_switch_pkg::CTRL_RESET[clk_switch_pkg::PLL_EN_BIT];
    end else if (!soft_pll) begin
      pll_en <= 1'b0; // RL9
    end else if (wr_ctrl) begin
      pll_en <= wdata_in[clk_switch_pkg::PLL_EN_BIT]; // RL9
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pll_sw <= clk_switch_pkg::CTRL_RESET[clk_switch_pkg::PLL_SW_BIT];
    end else if (!soft_pll || !pll_en_eff || !pll_stable) begin
      pll_sw <= 1'b0; // RL7 RL8
    end else if (wr_ctrl) begin
      pll_sw <= wdata_in[clk_switch_pkg::PLL_SW_BIT]; // RL7
    end
  end

  // Lock timer restarts whenever the reference oscillator was halted
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lock_cnt   <= '0;
      pll_stable <= 1'b0;
    end else if (!pll_en_eff || osc_halted) begin
      lock_cnt   <= '0;
      pll_stable <= 1'b0; // RL21
    end else if (lock_cnt == LOCK_LAST) begin
      pll_stable <= 1'b1; // RL10 RL21
    end else begin
      lock_cnt <= lock_cnt + 1'b1;
    end
  end

  // Switch sequencer
  clk_switch_pkg::sw_state_t state;
  clk_switch_pkg::src_t      active;
  clk_switch_pkg::src_t      tgt;
  clk_switch_pkg::src_t      want;
  logic [10:0]               edge_cnt;
  logic                      cur_level;
  logic                      tgt_rise;
  logic                      prim_rise;

  always_comb begin
    if (alt_sw) begin
      want = clk_switch_pkg::SRC_TIMER1; // RL11
    end else if (fixed_pll || pll_sw) begin
      want = clk_switch_pkg::SRC_PLL;
    end else begin
      want = clk_switch_pkg::SRC_PRIMARY; // RL4
    end
  end

  function automatic logic src_bit(input clk_switch_pkg::src_t s, input logic [3:0] v);
    unique case (s)
      clk_switch_pkg::SRC_PLL:    src_bit = v[2];
      clk_switch_pkg::SRC_TIMER1: src_bit = v[1];
      default:                    src_bit = v[0];
    endcase
  endfunction

  assign cur_level  = src_bit(active, sync_b);
  assign tgt_rise   = src_bit(tgt, rise);
  assign prim_rise  = rise[0];
  assign osc_halted = (state == clk_switch_pkg::ST_SLEEP) ||
                      (state == clk_switch_pkg::ST_WAKE) ||
                      (state == clk_switch_pkg::ST_START) ||
                      ((state == clk_switch_pkg::ST_RUN) &&
                       (active == clk_switch_pkg::SRC_TIMER1));

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state    <= clk_switch_pkg::ST_WAKE;
      active   <= clk_switch_pkg::SRC_PRIMARY; // RL5
      tgt      <= clk_switch_pkg::SRC_PRIMARY;
      edge_cnt <= 11'h000;
    end else begin
      unique case (state)
        clk_switch_pkg::ST_WAKE: begin
          edge_cnt <= 11'h000;
          if (cfg_done) begin
            tgt <= want;
            if (is_xtal && want != clk_switch_pkg::SRC_TIMER1) begin
              state <= clk_switch_pkg::ST_START; // RL20
            end else if (want == clk_switch_pkg::SRC_PLL) begin
              state <= clk_switch_pkg::ST_LOCK;
            end else begin
              state <= clk_switch_pkg::ST_SYNC;
            end
          end
        end
        clk_switch_pkg::ST_RUN: begin
          edge_cnt <= 11'h000;
          if (sleep_in) begin
            state <= clk_switch_pkg::ST_SLEEP;
          end else if (want != active && first_quarter_phase_in) begin
            tgt   <= want;
            state <= clk_switch_pkg::ST_PARK; // RL14
          end
        end
        clk_switch_pkg::ST_PARK: begin
          if (!cur_level) begin // RL22
            if (active == clk_switch_pkg::SRC_TIMER1 && is_xtal) begin
              state <= clk_switch_pkg::ST_START; // RL15 RL16
            end else if (tgt == clk_switch_pkg::SRC_PLL) begin
              state <= clk_switch_pkg::ST_LOCK; // RL17
            end else begin
              state <= clk_switch_pkg::ST_SYNC; // RL14 RL18
            end
          end
        end
        clk_switch_pkg::ST_START: begin
          if (prim_rise) begin
            if (edge_cnt == clk_switch_pkg::XTAL_START_EDGES - 11'h001) begin
              edge_cnt <= 11'h000;
              state    <= (tgt == clk_switch_pkg::SRC_PLL) ?
                          clk_switch_pkg::ST_LOCK : clk_switch_pkg::ST_SYNC; // RL16
            end else begin
              edge_cnt <= edge_cnt + 11'h001; // RL15
            end
          end
        end
        clk_switch_pkg::ST_LOCK: begin
          edge_cnt <= 11'h000;
          if (pll_stable) begin
            state <= clk_switch_pkg::ST_SYNC; // RL16 RL17
          end
        end
        clk_switch_pkg::ST_SYNC: begin
          if (tgt_rise) begin
            if (edge_cnt == clk_switch_pkg::SYNC_EDGES - 11'h001) begin
              edge_cnt <= 11'h000;
              active   <= tgt;
              state    <= clk_switch_pkg::ST_RUN; // RL13
            end else begin
              edge_cnt <= edge_cnt + 11'h001; // RL13
            end
          end
        end
        clk_switch_pkg::ST_SLEEP: begin
          edge_cnt <= 11'h000;
          if (!sleep_in) begin
            state <= clk_switch_pkg::ST_WAKE; // RL20
          end
        end
        default: begin
          state    <= clk_switch_pkg::ST_WAKE;
          edge_cnt <= 11'h000;
        end
      endcase
    end
  end

  // Generated clock follows the source; while parked it may only fall
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sys_clk_gen_out <= 1'b0;
    end else if (state == clk_switch_pkg::ST_RUN) begin
      sys_clk_gen_out <= cur_level;
    end else if (state == clk_switch_pkg::ST_PARK) begin
      sys_clk_gen_out <= cur_level && sys_clk_gen_out; // RL22
    end else begin
      sys_clk_gen_out <= 1'b0; // RL22
    end
  end

  assign cpu_freeze_out = (state != clk_switch_pkg::ST_RUN); // RL14

  // Output pin: divide-by-four, port bit, or left to the crystal
  logic div_half;
  logic div_q;

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      div_half <= 1'b0;
      div_q    <= 1'b0;
    end else if (prim_rise) begin
      div_half <= ~div_half;
      if (div_half) begin
        div_q <= ~div_q; // RL1
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      osc_out_pin_out      <= 1'b0;
      osc_out_pin_oe_n_out <= 1'b1;
      gpio_a_bit6_pin_out  <= 1'b0;
    end else begin
      gpio_a_bit6_pin_out <= gpio_mode ? sync_c[3] : 1'b0; // RL2
      if (rc_div_mode) begin
        osc_out_pin_out      <= div_q; // RL1
        osc_out_pin_oe_n_out <= 1'b0;
      end else if (gpio_mode) begin
        osc_out_pin_out      <= gpio_a_bit6_val_in; // RL2
        osc_out_pin_oe_n_out <= gpio_a_bit6_oe_n_in;
      end else begin
        osc_out_pin_out      <= 1'b0;
        osc_out_pin_oe_n_out <= 1'b1;
      end
    end
  end

  // Read port, data in the cycle after the strobe
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in && addr_in == clk_switch_pkg::ADDR_CTRL) begin
      rdata_out <= {4'h0, pll_stable, pll_en_eff, pll_sw, alt_sw}; // RL12 RL10
    end else if (rd_in && addr_in == clk_switch_pkg::ADDR_STATUS) begin
      rdata_out <= {mode, 1'b0, cpu_freeze_out, active};
    end else begin
      rdata_out <= 8'h00;
    end
  end

endmodule

`default_nettype wire

//--- tb/clk_switch_props.sv
// Purpose: Port-level checks for the system clock switch.
// Assumes: Mode and switch-enable inputs change only during reset; Timer1 enable may change at any time.
// Notes:   Bound to the top module.
`timescale 1ns/10ps
`default_nettype none
module clk_switch_props (
  input wire logic       sys_clk_in,
  input wire logic       nrst_in,
  input wire logic [3:0] addr_in,
  input wire logic       rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic [3:0] main_osc_config_in,
  input wire logic       clock_switch_enable_n_in,
  input wire logic       timer1_osc_enable_in,
  input wire logic       gpio_a_bit6_oe_n_in,
  input wire logic       osc_out_pin_oe_n_out,
  input wire logic       sys_clk_gen_out,
  input wire logic       cpu_freeze_out
);
  logic rd_ctrl;
  logic fixed;
  logic soft_mode;
  assign rd_ctrl = rd_in && addr_in == clk_switch_pkg::ADDR_CTRL;
  assign fixed = main_osc_config_in inside {4'h6, 4'h9};
  assign soft_mode = main_osc_config_in inside {4'h8, 4'ha};
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  chk_upper_zero: assert property (rd_ctrl |=> rdata_out[7:4] == 4'h0)
    else $error("upper control bits set");
  chk_alt_cfg_off: assert property (rd_ctrl && clock_switch_enable_n_in |=> !rdata_out[0])
    else $error("alt switch set while switching disabled");
  chk_alt_t1_off: assert property ((!timer1_osc_enable_in)[*3] ##0 rd_ctrl |=> !rdata_out[0])
    else $error("alt switch set without timer1");
  chk_pll_en_fixed: assert property (rd_ctrl && fixed |=> rdata_out[2])
    else $error("pll enable not one in fixed mode");
  chk_pll_en_off: assert property (rd_ctrl && !fixed && !soft_mode |=> !rdata_out[2])
    else $error("pll enable set in non pll mode");
  chk_pll_sw_fixed: assert property (rd_ctrl && fixed |=> !rdata_out[1])
    else $error("pll switch set in fixed mode");
  chk_lock_needs_en: assert property (rd_ctrl |=> !rdata_out[3] || rdata_out[2])
    else $error("stable flag without pll enable");
  chk_pll_sw_gate: assert property (rd_ctrl |=> !rdata_out[1] || rdata_out[3:2] == 2'b11)
    else $error("pll switch set while unlocked");
  chk_rc_drive: assert property (main_osc_config_in == 4'h3 && $past(nrst_in, 3)
      |-> !osc_out_pin_oe_n_out)
    else $error("output pin not driven in rc mode");
  chk_gpio_hand: assert property (main_osc_config_in == 4'h7 && $past(nrst_in, 3)
      && gpio_a_bit6_oe_n_in && $past(gpio_a_bit6_oe_n_in) |-> osc_out_pin_oe_n_out)
    else $error("output pin driven while port bit released");
  chk_park_low: assert property (cpu_freeze_out && $past(cpu_freeze_out)
      && !$past(sys_clk_gen_out) |-> !sys_clk_gen_out)
    else $error("generated clock rose while parked");
endmodule
bind system_clock_switch clk_switch_props clk_switch_props_inst (
  .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .addr_in(addr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .main_osc_config_in(main_osc_config_in),
  .clock_switch_enable_n_in(clock_switch_enable_n_in),
  .timer1_osc_enable_in(timer1_osc_enable_in), .gpio_a_bit6_oe_n_in(gpio_a_bit6_oe_n_in),
  .osc_out_pin_oe_n_out(osc_out_pin_oe_n_out), .sys_clk_gen_out(sys_clk_gen_out),
  .cpu_freeze_out(cpu_freeze_out));
`default_nettype wire

//--- tb/osc_sources.sv
// Purpose: Oscillator sources seen at the clock switch pins.
// Assumes: Crystal, Timer1 and PLL clocks all run freely.
// Notes:   Periods are arbitrary simulation values.
`timescale 1ns/10ps
`default_nettype none
module osc_sources #(
  parameter int OSC_NS = 48,
  parameter int T1_NS  = 208,
  parameter int PLL_NS = 32
) (
  output logic osc_out,
  output logic t1_out,
  output logic pll_out
);
  initial begin
    osc_out = 1'b0;
    forever #(OSC_NS / 2) osc_out = ~osc_out;
  end
  initial begin
    t1_out = 1'b0;
    forever #(T1_NS / 2) t1_out = ~t1_out;
  end
  initial begin
    pll_out = 1'b0;
    forever #(PLL_NS / 2) pll_out = ~pll_out;
  end
endmodule
`default_nettype wire

//--- tb/system_clock_switch_test.sv
// Purpose: Self-checking bench for the system clock switch.
// Assumes: Lock wait shortened to LOCK cycles.
// Notes:   Mode codes change only across a reset.
`timescale 1ns/10ps
`default_nettype none
module system_clock_switch_test;
  localparam int LOCK = 20;
  logic       sys_clk_in, nrst_in, wr_in, rd_in, timer1_osc_enable_in;
  logic       clock_switch_enable_n_in, first_quarter_phase_in;
  logic       gpio_a_bit6_val_in, gpio_a_bit6_oe_n_in, osc_out_pin_out;
  logic       osc_out_pin_oe_n_out, gpio_a_bit6_pin_out, sys_clk_gen_out, cpu_freeze_out;
  logic       osc_in_pin_in, timer1_osc_in, pll_clk_in, sleep_in;
  logic [3:0] addr_in, main_osc_config_in;
  logic [7:0] wdata_in, rdata_out;
  logic [1:0] ph;
  wire logic  osc_out_pin_in;
  int         error_cnt, cmp_count, cyc, n;
  assign osc_out_pin_in = osc_out_pin_oe_n_out ? 1'b1 : osc_out_pin_out;
  system_clock_switch #(.LOCK_CYCLES(LOCK)) system_clock_switch_inst (
    .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .main_osc_config_in(main_osc_config_in), .clock_switch_enable_n_in(clock_switch_enable_n_in),
    .timer1_osc_enable_in(timer1_osc_enable_in), .first_quarter_phase_in(first_quarter_phase_in),
    .sleep_in(sleep_in), .osc_in_pin_in(osc_in_pin_in), .timer1_osc_in(timer1_osc_in),
    .pll_clk_in(pll_clk_in), .osc_out_pin_in(osc_out_pin_in), .osc_out_pin_out(osc_out_pin_out),
    .osc_out_pin_oe_n_out(osc_out_pin_oe_n_out), .gpio_a_bit6_val_in(gpio_a_bit6_val_in),
    .gpio_a_bit6_oe_n_in(gpio_a_bit6_oe_n_in), .gpio_a_bit6_pin_out(gpio_a_bit6_pin_out),
    .sys_clk_gen_out(sys_clk_gen_out), .cpu_freeze_out(cpu_freeze_out));
  osc_sources osc_sources_inst (
    .osc_out(osc_in_pin_in), .t1_out(timer1_osc_in), .pll_out(pll_clk_in));
  initial begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) begin
    ph <= ph + 2'd1;
    first_quarter_phase_in <= (ph == 2'd3);
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt++;
      close_out();
    end
  end
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge sys_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    #1 chk(rdata_out & m, e);
  endtask
  task automatic boot(input logic [3:0] m, input logic en_n);
    if (nrst_in)
      @(posedge sys_clk_in);
    nrst_in <= 1'b0;
    main_osc_config_in <= m;
    clock_switch_enable_n_in <= en_n;
    timer1_osc_enable_in <= 1'b0;
    repeat (20) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
  endtask
  // Waits for the transition to finish
  task automatic settle;
    int k;
    k = 0;
    repeat (8) @(posedge sys_clk_in);
    while (cpu_freeze_out !== 1'b0 && k < 9000) begin
      @(posedge sys_clk_in);
      k++;
    end
    chk(cpu_freeze_out, 1'b0);
  endtask
  // Counts source rises while frozen
  task automatic span(input logic use_t1, output int r);
    logic prev, cur;
    int   k;
    r = 0;
    k = 0;
    while (cpu_freeze_out !== 1'b1 && k < 20) begin
      @(posedge sys_clk_in);
      k++;
    end
    prev = use_t1 ? timer1_osc_in : osc_in_pin_in;
    while (cpu_freeze_out === 1'b1 && k < 9000) begin
      @(posedge sys_clk_in);
      k++;
      cur = use_t1 ? timer1_osc_in : osc_in_pin_in;
      if (cur && !prev)
        r++;
      prev = cur;
    end
  endtask
  task automatic crystal_switching;
    boot(4'h2, 1'b0);
    settle();
    rdc(4'h0, 8'hff, 8'h00);
    wr(4'h0, 8'hff);
    rdc(4'h0, 8'hff, 8'h00);
    rdc(4'h5, 8'hff, 8'h00);
    wr(4'h1, 8'h03);
    rdc(4'h1, 8'hff, 8'h20);
    timer1_osc_enable_in <= 1'b1;
    wr(4'h0, 8'h01);
    span(1'b1, n);
    chk(8'(n >= 8 && n <= 9), 8'h01);
    rdc(4'h0, 8'hff, 8'h01);
    rdc(4'h1, 8'hff, 8'h22);
    wr(4'h0, 8'h00);
    span(1'b0, n);
    chk(8'(n >= 1032 && n <= 1036), 8'h01);
    rdc(4'h1, 8'hff, 8'h20);
    sleep_in <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    chk({cpu_freeze_out, sys_clk_gen_out}, 8'h02);
    sleep_in <= 1'b0;
    span(1'b0, n);
    chk(8'(n >= 1032 && n <= 1036), 8'h01);
    $display("test crystal_switching done");
  endtask
  task automatic switching_locked;
    boot(4'h2, 1'b1);
    timer1_osc_enable_in <= 1'b1;
    wr(4'h0, 8'h01);
    rdc(4'h0, 8'hff, 8'h00);
    $display("test switching_locked done");
  endtask
  task automatic soft_pll;
    boot(4'ha, 1'b0);
    settle();
    wr(4'h0, 8'h04);
    rdc(4'h0, 8'hff, 8'h04);
    repeat (LOCK + 20) @(posedge sys_clk_in);
    rdc(4'h0, 8'hff, 8'h0c);
    wr(4'h0, 8'h06);
    settle();
    rdc(4'h1, 8'hff, 8'ha1);
    timer1_osc_enable_in <= 1'b1;
    wr(4'h0, 8'h07);
    settle();
    rdc(4'h1, 8'hff, 8'ha2);
    wr(4'h0, 8'h00);
    rdc(4'h0, 8'hff, 8'h00);
    settle();
    boot(4'h6, 1'b0);
    settle();
    wr(4'h0, 8'h02);
    rdc(4'h0, 8'h07, 8'h04);
    $display("test soft_pll done");
  endtask
  task automatic pin_modes;
    int rises, flips;
    logic po, pc;
    boot(4'h3, 1'b0);
    settle();
    rises = 0;
    flips = 0;
    po = osc_out_pin_out;
    pc = osc_in_pin_in;
    repeat (400) begin
      @(posedge sys_clk_in);
      if (osc_in_pin_in && !pc)
        rises++;
      if (osc_out_pin_out !== po)
        flips++;
      po = osc_out_pin_out;
      pc = osc_in_pin_in;
    end
    chk(8'(rises >= 2 * flips - 2 && rises <= 2 * flips + 2 && flips > 20), 8'h01);
    chk(osc_out_pin_oe_n_out, 1'b0);
    boot(4'h7, 1'b0);
    gpio_a_bit6_val_in <= 1'b0;
    gpio_a_bit6_oe_n_in <= 1'b0;
    repeat (6) @(posedge sys_clk_in);
    chk({osc_out_pin_oe_n_out, osc_out_pin_out, gpio_a_bit6_pin_out}, 8'h00);
    gpio_a_bit6_oe_n_in <= 1'b1;
    repeat (6) @(posedge sys_clk_in);
    chk({osc_out_pin_oe_n_out, gpio_a_bit6_pin_out}, 8'h03);
    $display("test pin_modes done");
  endtask
  initial begin
    {nrst_in, wr_in, rd_in, timer1_osc_enable_in, first_quarter_phase_in, sleep_in} = '0;
    {gpio_a_bit6_val_in, gpio_a_bit6_oe_n_in, clock_switch_enable_n_in} = 3'b011;
    {addr_in, main_osc_config_in, wdata_in, ph} = '0;
    {error_cnt, cmp_count, cyc} = '0;
    crystal_switching();
    switching_locked();
    soft_pll();
    pin_modes();
    close_out();
  end
endmodule
`default_nettype wire
